// *** hdl/pgag_defs.vh ***
// constants for the parameter group access guard: apb offsets,
// status and command bits, protect levels and group masks.
// assumes a 12-bit apb byte address and 32-bit data.
`ifndef PGAG_DEFS_VH
`define PGAG_DEFS_VH

// apb address width and register byte offsets
`define PGAG_ADDR_W          12
`define PGAG_OFF_LEVEL_SET   12'h000
`define PGAG_OFF_LEVEL_ACT   12'h004
`define PGAG_OFF_STATUS      12'h008
`define PGAG_OFF_COMMAND     12'h00c

// parameter windows, selected by paddr[11:10]
`define PGAG_WIN_SET         2'h1
`define PGAG_WIN_ACT         2'h2

// group codes, paddr[9:7] inside a window
`define PGAG_GRP_BASIC       3'h0
`define PGAG_GRP_GAIN        3'h1
`define PGAG_GRP_EXT         3'h2
`define PGAG_GRP_IO          3'h3
`define PGAG_GRP_SPECIAL     3'h4
`define PGAG_GRP_OPTION      3'h5
`define PGAG_NUM_GROUPS      3'h6
`define PGAG_NUM_ENTRIES     192

// the protect level also appears as basic group entry 19
`define PGAG_LEVEL_PARAM_NUM 5'h13

// protect level codes
`define PGAG_LEVEL_RESET     16'h000b
`define PGAG_LVL_BASIC       16'h0000
`define PGAG_LVL_STD         16'h000b
`define PGAG_LVL_IO          16'h000c
`define PGAG_LVL_SPECIAL     16'h000d
`define PGAG_LVL_ALL         16'h000e
`define PGAG_LVL_RO_STD      16'h100b
`define PGAG_LVL_RO_IO       16'h100c
`define PGAG_LVL_RO_SPECIAL  16'h100d
`define PGAG_LVL_RO_ALL      16'h100e

// group masks, bit n = group code n
`define PGAG_MASK_NONE       6'h00
`define PGAG_MASK_BASIC      6'h01
`define PGAG_MASK_STD        6'h07
`define PGAG_MASK_IO         6'h0f
`define PGAG_MASK_SPECIAL    6'h1f
`define PGAG_MASK_ALL        6'h3f

// status bits
`define PGAG_STS_RD_REFUSED  0
`define PGAG_STS_WR_REFUSED  1
`define PGAG_STS_LEVEL_PEND  2
`define PGAG_STS_PARAM_PEND  3

// command bits (write one to trigger)
`define PGAG_CMD_CTRL_RESET  0
`define PGAG_CMD_POWER_CYCLE 1

// activation classes
`define PGAG_DEFER_NONE      2'h0
`define PGAG_DEFER_SOFT      2'h1
`define PGAG_DEFER_POWER     2'h2

`endif

// *** hdl/pgag_level_decode.v ***
// protect level decoder: turns a level code into read and write group masks.
// assumes a stable level input on the same clock as its user.
`timescale 1ns/1ps
`default_nettype none
`include "pgag_defs.vh"

module pgag_level_decode (
    input  wire [15:0] level,
    output reg  [5:0]  rd_mask,
    output reg  [5:0]  wr_mask
);

    // level to masks; unknown codes open nothing
    always @* begin
        rd_mask = `PGAG_MASK_NONE;
        wr_mask = `PGAG_MASK_NONE;
        case (level)
            `PGAG_LVL_BASIC: begin
                rd_mask = `PGAG_MASK_BASIC; // R2
                wr_mask = `PGAG_MASK_BASIC; // R2
            end
            `PGAG_LVL_STD: begin
                rd_mask = `PGAG_MASK_STD; // R3
                wr_mask = `PGAG_MASK_STD; // R3
            end
            `PGAG_LVL_IO: begin
                rd_mask = `PGAG_MASK_IO; // R4
                wr_mask = `PGAG_MASK_IO; // R4
            end
            `PGAG_LVL_SPECIAL: begin
                rd_mask = `PGAG_MASK_SPECIAL; // R4
                wr_mask = `PGAG_MASK_SPECIAL; // R4
            end
            `PGAG_LVL_ALL: begin
                rd_mask = `PGAG_MASK_ALL; // R4
                wr_mask = `PGAG_MASK_ALL; // R4
            end
            // read-only family: writes shut, level register handled outside
            `PGAG_LVL_RO_STD:     rd_mask = `PGAG_MASK_STD; // R5
            `PGAG_LVL_RO_IO:      rd_mask = `PGAG_MASK_IO; // R5
            `PGAG_LVL_RO_SPECIAL: rd_mask = `PGAG_MASK_SPECIAL; // R5
            `PGAG_LVL_RO_ALL:     rd_mask = `PGAG_MASK_ALL; // R5
            default: begin
                rd_mask = `PGAG_MASK_NONE;
                wr_mask = `PGAG_MASK_NONE;
            end
        endcase
    end

endmodule // pgag_level_decode
`default_nettype wire

// *** hdl/pgag_param_store.v ***
// parameter store: set values, active values and deferred activation.
// assumes one write per cycle and apply pulses one cycle wide.
`timescale 1ns/1ps
`default_nettype none
`include "pgag_defs.vh"

module pgag_param_store #(
    parameter ENTRIES = `PGAG_NUM_ENTRIES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        wr_en,
    input  wire [7:0]  wr_idx,
    input  wire [15:0] wr_data,
    input  wire [7:0]  rd_idx,
    input  wire        rd_active,
    output wire [15:0] rd_data,
    input  wire        apply_soft,
    input  wire        apply_power,
    output wire        any_pend
);

    reg [15:0]        set_q [0:ENTRIES-1];
    reg [15:0]        act_q [0:ENTRIES-1];
    reg [ENTRIES-1:0] pend_q;
    integer           i;

    // activation class of an entry, fixed per parameter
    function [1:0] defer_class;
        input [7:0] idx;
        begin
            case (idx)
                8'h01, 8'h02:               defer_class = `PGAG_DEFER_POWER;
                8'h03, 8'h04, 8'h0e, 8'h0f: defer_class = `PGAG_DEFER_SOFT;
                default:                    defer_class = `PGAG_DEFER_NONE;
            endcase
        end
    endfunction

    assign rd_data  = rd_active ? act_q[rd_idx] : set_q[rd_idx];
    assign any_pend = |pend_q;

    // storage, apply sweep, then the write so a write wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= {ENTRIES{1'b0}};
            for (i = 0; i < ENTRIES; i = i + 1) begin
                set_q[i] <= 16'h0000;
                act_q[i] <= 16'h0000;
            end
        end else begin
            for (i = 0; i < ENTRIES; i = i + 1) begin
                if (pend_q[i] && ((defer_class(i[7:0]) == `PGAG_DEFER_SOFT &&
                                   (apply_soft || apply_power)) ||
                                  (defer_class(i[7:0]) == `PGAG_DEFER_POWER &&
                                   apply_power))) begin
                    act_q[i]  <= set_q[i]; // R8
                    pend_q[i] <= 1'b0;
                end
            end
            if (wr_en) begin
                set_q[wr_idx] <= wr_data;
                if (defer_class(wr_idx) == `PGAG_DEFER_NONE) begin
                    act_q[wr_idx] <= wr_data;
                end else begin
                    pend_q[wr_idx] <= 1'b1; // R8
                end
            end
        end
    end

endmodule // pgag_param_store
`default_nettype wire

// *** hdl/pgag_top.v ***
// parameter group access guard: apb slave in front of a grouped
// parameter store, gated by a protect level that activates on reset.
// map: 0x000 level setting, 0x004 level in force, 0x008 status,
// 0x00c command, parameters from 0x400 (set) and 0x800 (in force).
// assumes an apb master on pclk; every request answers after one wait.
//
// Operation
// R1: parameters sit in six groups; access granted per group by protect level.
// R2: level 0000h opens only the basic group for read and write.
// R3: default level 000Bh opens basic, gain/filter and extension groups.
// R4: 000Ch adds I/O, 000Dh adds special, 000Eh opens all six.
// R5: 100Bh-100Eh read like 000x; only the protect level itself is writable.
// R6: a parameter request is carried out only if its group permits it.
// R7: a new protect level takes effect only after controller reset or power cycle.
// R8: deferred parameters activate on either reset; double-deferred only on power cycle.
// R9: the accessing party leaves fixed-value digits unchanged when writing.
// R10: refused writes change nothing; refused reads return zero and report an error.
`timescale 1ns/1ps
`default_nettype none
`include "pgag_defs.vh"

module pgag_top #(
    parameter ENTRIES = `PGAG_NUM_ENTRIES
) (
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [`PGAG_ADDR_W-1:0] paddr,
    input  wire [31:0]             pwdata,
    input  wire [3:0]              pstrb,
    output reg  [31:0]             prdata,
    output reg                     pready,
    output reg                     pslverr,
    output reg  [15:0]             active_level_q,
    output reg  [5:0]              read_enable_mask_q,
    output reg  [5:0]              write_enable_mask_q,
    output reg                     deferred_pending_q
);

    // protect level: software copy and the one in force
    reg  [15:0] level_set_q;
    reg  [15:0] level_act_q;

    // sticky refusal flags and apply pulses
    reg         rd_refused_q;
    reg         wr_refused_q;
    reg         apply_soft_q;
    reg         apply_power_q;

    // decoder and store results
    wire [5:0]  rd_mask;
    wire [5:0]  wr_mask;
    wire [15:0] store_rd_data;
    wire        store_pend;

    // apb phases
    wire        access_ph;
    wire        respond;
    wire        commit;
    wire        commit_wr;

    // address decode
    wire [1:0]  win;
    wire [2:0]  grp;
    wire [4:0]  num;
    wire        word_ok;
    wire        in_set;
    wire        in_act;

    wire        is_level_param;
    wire        hit_lset;
    wire        hit_lact;
    wire        hit_sts;
    wire        hit_cmd;
    wire        in_param;

    wire [5:0]  grp_bit;
    wire        grp_rd_ok;
    wire        grp_wr_ok;
    wire        param_ok;

    wire        guard_refused;
    reg         access_err;

    // write data merge and read mux
    wire [15:0] lane_mask;
    wire [15:0] level_merged;
    wire [15:0] param_merged;
    wire        level_pend;
    wire        store_wr_en;
    reg  [31:0] rd_val;

    // status strobes: refusal sets and write-one-to-clear
    wire        clr_rd;
    wire        clr_wr;
    wire        set_rd;
    wire        set_wr;

    // masks follow the level in force, never the pending one
    // a new level waits for a reset command
    pgag_level_decode u_decode (
        .level   (level_act_q), // R7
        .rd_mask (rd_mask),
        .wr_mask (wr_mask)
    );

    // parameter storage with deferred activation
    pgag_param_store #(
        .ENTRIES (ENTRIES)
    ) u_store (
        .pclk        (pclk),
        .presetn     (presetn),
        .wr_en       (store_wr_en),
        .wr_idx      ({grp, num}),
        .wr_data     (param_merged),
        .rd_idx      ({grp, num}),
        .rd_active   (in_act),
        .rd_data     (store_rd_data),
        .apply_soft  (apply_soft_q),
        .apply_power (apply_power_q),
        .any_pend    (store_pend)
    );

    // phase strobes: respond on first access cycle, commit when pready seen
    // a refused access never commits a write
    assign access_ph = psel & penable;
    assign respond   = access_ph & ~pready;
    assign commit    = access_ph & pready;
    assign commit_wr = commit & pwrite & ~pslverr; // R10

    // window, group and entry fields of the address
    // sub-word addresses fall through to an error
    assign win     = paddr[11:10];
    assign grp     = paddr[9:7];
    assign num     = paddr[6:2];
    assign word_ok = (paddr[1:0] == 2'h0);
    assign in_set  = word_ok & (win == `PGAG_WIN_SET) &
                     (grp < `PGAG_NUM_GROUPS); // R1
    assign in_act  = word_ok & (win == `PGAG_WIN_ACT) &
                     (grp < `PGAG_NUM_GROUPS); // R1

    // the protect level answers at its own offset and as basic entry 19
    assign is_level_param = in_set & (grp == `PGAG_GRP_BASIC) &
                            (num == `PGAG_LEVEL_PARAM_NUM);
    assign hit_lset = (paddr == `PGAG_OFF_LEVEL_SET) | is_level_param;
    assign hit_lact = (paddr == `PGAG_OFF_LEVEL_ACT);
    assign hit_sts  = (paddr == `PGAG_OFF_STATUS);
    assign hit_cmd  = (paddr == `PGAG_OFF_COMMAND);
    assign in_param = (in_set | in_act) & ~is_level_param;

    // group permission under the level in force
    // an unknown level leaves both masks empty
    assign grp_bit   = 6'h01 << grp;
    assign grp_rd_ok = |(rd_mask & grp_bit); // R6
    assign grp_wr_ok = |(wr_mask & grp_bit); // R6
    assign param_ok  = pwrite ? (in_set & grp_wr_ok) : grp_rd_ok; // R6

    // the level register stays writable in every level
    assign guard_refused = in_param & ~param_ok; // R5 R6

    // bus error by target; unmapped words err
    always @* begin
        access_err = 1'b1;
        if (hit_lset) begin
            access_err = 1'b0; // R5
        end else if (hit_lact) begin
            access_err = pwrite;
        end else if (hit_sts | hit_cmd) begin
            access_err = 1'b0;
        end else if (in_param) begin
            access_err = ~param_ok; // R10
        end
    end

    // byte lanes of the low half-word
    assign lane_mask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign level_merged = (level_set_q & ~lane_mask) |
                          (pwdata[15:0] & lane_mask);
    assign param_merged = (store_rd_data & ~lane_mask) |
                          (pwdata[15:0] & lane_mask);
    assign store_wr_en  = commit_wr & in_param; // R6 R10

    // a written level not yet in force
    assign level_pend = (level_set_q != level_act_q);

    // read data by target; refused reads yield zero
    // the command register reads as zero
    always @* begin
        rd_val = 32'h0000_0000;
        if (hit_lset) begin
            rd_val = {16'h0000, level_set_q};
        end else if (hit_lact) begin
            rd_val = {16'h0000, level_act_q};
        end else if (hit_sts) begin
            rd_val[`PGAG_STS_RD_REFUSED] = rd_refused_q;
            rd_val[`PGAG_STS_WR_REFUSED] = wr_refused_q;
            rd_val[`PGAG_STS_LEVEL_PEND] = level_pend;
            rd_val[`PGAG_STS_PARAM_PEND] = store_pend;
        end else if (in_param & param_ok) begin
            rd_val = {16'h0000, store_rd_data}; // R6
        end
    end

    // apb answer: one wait state, then pready for one cycle
    // the wait state lets the decode settle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (respond) begin
            pready  <= 1'b1;
            pslverr <= access_err; // R10
            prdata  <= (pwrite | access_err) ? 32'h0000_0000 :
                       rd_val; // R10
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // software copy of the protect level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_set_q <= `PGAG_LEVEL_RESET;
        end else if (commit_wr & hit_lset) begin
            level_set_q <= level_merged; // R5
        end
    end

    // reset commands become one-cycle apply pulses
    // registered, so level and store move on one edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apply_soft_q  <= 1'b0;
            apply_power_q <= 1'b0;
        end else begin
            apply_soft_q  <= commit_wr & hit_cmd & pstrb[0] &
                             pwdata[`PGAG_CMD_CTRL_RESET];
            apply_power_q <= commit_wr & hit_cmd & pstrb[0] &
                             pwdata[`PGAG_CMD_POWER_CYCLE];
        end
    end

    // level in force changes only on a reset command
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_act_q <= `PGAG_LEVEL_RESET;
        end else if (apply_soft_q | apply_power_q) begin
            level_act_q <= level_set_q; // R7
        end
    end

    // status strobes: refusal seen at respond, clear at commit
    assign set_rd = respond & guard_refused & ~pwrite;
    assign set_wr = respond & guard_refused & pwrite;
    assign clr_rd = commit_wr & hit_sts & pstrb[0] &
                    pwdata[`PGAG_STS_RD_REFUSED];
    assign clr_wr = commit_wr & hit_sts & pstrb[0] &
                    pwdata[`PGAG_STS_WR_REFUSED];

    // sticky refusal flags, a new refusal beats a clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_refused_q <= 1'b0;
        end else begin
            rd_refused_q <= (rd_refused_q & ~clr_rd) | set_rd; // R10
        end
    end

    // write refusal flag, same priority
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_refused_q <= 1'b0;
        end else begin
            wr_refused_q <= (wr_refused_q & ~clr_wr) | set_wr; // R10
        end
    end

    // registered copies of the guard state for the rest of the chip
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_level_q      <= `PGAG_LEVEL_RESET;
            deferred_pending_q  <= 1'b0;
        end else begin
            active_level_q      <= level_act_q;
            deferred_pending_q  <= level_pend | store_pend; // R8
        end
    end

    // group masks, moving on the same edge as the level copy
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_enable_mask_q  <= `PGAG_MASK_STD;
            write_enable_mask_q <= `PGAG_MASK_STD;
        end else begin
            read_enable_mask_q  <= rd_mask; // R1
            write_enable_mask_q <= wr_mask; // R1
        end
    end

endmodule // pgag_top
`default_nettype wire

// *** sim/pgag_properties.sv ***
// concurrent checks on the access guard top ports
// assumes one clock pclk and async active-low presetn
`timescale 1ns/1ps
`default_nettype none
`include "pgag_defs.vh"

module pgag_properties #(
    parameter ENTRIES = 192
) (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`PGAG_ADDR_W-1:0] paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic [15:0]             active_level_q,
    input wire logic [5:0]              read_enable_mask_q,
    input wire logic [5:0]              write_enable_mask_q,
    input wire logic                    deferred_pending_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // command commit history, one to three edges back
    logic cmd_q1;
    logic cmd_q2;
    logic cmd_q3;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q1 <= 1'b0;
            cmd_q2 <= 1'b0;
            cmd_q3 <= 1'b0;
        end else begin
            cmd_q1 <= psel && penable && pready && pwrite && paddr == `PGAG_OFF_COMMAND;
            cmd_q2 <= cmd_q1;
            cmd_q3 <= cmd_q2;
        end
    end

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence

    ready_one_wait_a: assert property (
        setup_s ##1 access_s |=> pready) else $error("no answer after one wait");
    ready_pulse_a: assert property (
        pready |=> !pready) else $error("pready longer than one cycle");
    err_with_ready_a: assert property (
        pslverr |-> pready && psel && penable) else $error("pslverr outside answer");
    refused_data_zero_a: assert property (
        (!pready || pslverr) |-> prdata == 32'h0) else $error("data leaks on refusal");
    write_within_read_a: assert property (
        (write_enable_mask_q & ~read_enable_mask_q) == 6'h00) else $error("write wider than read");
    level_deferred_a: assert property (
        $changed(active_level_q) |-> cmd_q2 || cmd_q3) else $error("level moved without reset");
    act_write_refused_a: assert property (
        setup_s ##1 (psel && penable && pwrite && paddr == `PGAG_OFF_LEVEL_ACT) |=> pslverr)
        else $error("write to level in force accepted");
    level_set_open_a: assert property (
        setup_s ##1 (psel && penable && paddr == `PGAG_OFF_LEVEL_SET) |=> pready && !pslverr)
        else $error("level setting refused");
    mask_basic_a: assert property (
        active_level_q == 16'h0000 |-> read_enable_mask_q == 6'h01 && write_enable_mask_q == 6'h01)
        else $error("basic level masks wrong");
    mask_std_a: assert property (
        active_level_q == 16'h000b |-> read_enable_mask_q == 6'h07 && write_enable_mask_q == 6'h07)
        else $error("default level masks wrong");
    mask_ro_all_a: assert property (
        active_level_q == 16'h100e |-> read_enable_mask_q == 6'h3f && write_enable_mask_q == 6'h00)
        else $error("read-only level masks wrong");
endmodule // pgag_properties

bind pgag_top pgag_properties #(.ENTRIES(ENTRIES)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .active_level_q(active_level_q),
    .read_enable_mask_q(read_enable_mask_q), .write_enable_mask_q(write_enable_mask_q),
    .deferred_pending_q(deferred_pending_q));
`default_nettype wire

// *** sim/pgag_apb_master.sv ***
// apb master standing for the controller or setup tool
// assumes pclk shared with the guard; changes signals after rising edges
`timescale 1ns/1ps
`default_nettype none

module pgag_apb_master (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
    end

    // one transfer; full values written as given, fixed digits kept by caller
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released data no longer valid
    endtask
endmodule // pgag_apb_master
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the access guard
// assumes the apb master model drives every bus input
`timescale 1ns/1ps
`default_nettype none
`include "pgag_defs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %0s expected %h seen %h", n, e, g); end end

module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, pend;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [15:0] lvl;
    logic [5:0]  rmask, wmask;
    int          mismatches = 0;
    int          checks_done = 0;
    logic [15:0] ex [6];
    logic [15:0] lvls [9] = '{16'h000b, 16'h0000, 16'h000c, 16'h000d, 16'h000e,
                              16'h100b, 16'h100c, 16'h100d, 16'h100e};

    always #5 pclk = ~pclk;

    pgag_apb_master mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    pgag_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .active_level_q(lvl),
        .read_enable_mask_q(rmask), .write_enable_mask_q(wmask), .deferred_pending_q(pend));

    // set and active window addresses
    function automatic logic [11:0] pa(input int g, input int n);
        return 12'h400 + g * 128 + n * 4;
    endfunction
    function automatic logic [11:0] aa(input int g, input int n);
        return 12'h800 + g * 128 + n * 4;
    endfunction
    // expected {read, write} group masks per level
    function automatic logic [11:0] masks(input logic [15:0] l);
        case (l)
            16'h0000: return {6'h01, 6'h01};
            16'h000b: return {6'h07, 6'h07};
            16'h000c: return {6'h0f, 6'h0f};
            16'h000d: return {6'h1f, 6'h1f};
            16'h000e: return {6'h3f, 6'h3f};
            16'h100b: return {6'h07, 6'h00};
            16'h100c: return {6'h0f, 6'h00};
            16'h100d: return {6'h1f, 6'h00};
            default:  return {6'h3f, 6'h00};
        endcase
    endfunction

    // one access with expected refusal and read data
    task automatic rw(input logic w, input logic [11:0] a, input logic [15:0] d,
                      input logic ee, input logic [15:0] ed);
        logic [31:0] r;
        logic        e;
        mst.xfer(w, a, {16'h0, d}, r, e);
        `CHK("refusal", ee, e)
        if (!w) `CHK("read data", {16'h0, ed}, r)
    endtask
    task automatic cmd(input logic [1:0] b);
        rw(1'b1, `PGAG_OFF_COMMAND, {14'h0, b}, 1'b0, 16'h0);
        repeat (3) @(posedge pclk);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog for a hung handshake
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        close_out;
    end

    initial begin
        logic [11:0] m;
        logic [15:0] cur;
        logic [15:0] v;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rw(1'b0, `PGAG_OFF_LEVEL_SET, 16'h0, 1'b0, 16'h000b);
        rw(1'b0, `PGAG_OFF_LEVEL_ACT, 16'h0, 1'b0, 16'h000b);
        $display("test reset done");
        // deferred and double-deferred basic entries
        rw(1'b1, pa(0, 3), 16'h1234, 1'b0, 16'h0);
        rw(1'b1, pa(0, 1), 16'h5678, 1'b0, 16'h0);
        rw(1'b0, aa(0, 3), 16'h0, 1'b0, 16'h0000);
        rw(1'b0, `PGAG_OFF_STATUS, 16'h0, 1'b0, 16'h0008);
        `CHK("pending", 1'b1, pend)
        cmd(2'h1);
        rw(1'b0, aa(0, 3), 16'h0, 1'b0, 16'h1234);
        rw(1'b0, aa(0, 1), 16'h0, 1'b0, 16'h0000);
        cmd(2'h2);
        rw(1'b0, aa(0, 1), 16'h0, 1'b0, 16'h5678);
        `CHK("pending", 1'b0, pend)
        rw(1'b1, `PGAG_OFF_LEVEL_ACT, 16'h000e, 1'b1, 16'h0);
        rw(1'b0, 12'h010, 16'h0, 1'b1, 16'h0);
        rw(1'b1, aa(0, 5), 16'h0001, 1'b1, 16'h0);
        $display("test deferral done");
        // every level against every group
        for (int g = 0; g < 6; g++) ex[g] = 16'h0;
        cur = 16'h000b;
        for (int i = 0; i < 9; i++) begin
            m = masks(lvls[i]);
            rw(1'b1, `PGAG_OFF_LEVEL_SET, lvls[i], 1'b0, 16'h0);
            rw(1'b0, `PGAG_OFF_LEVEL_ACT, 16'h0, 1'b0, cur);
            cmd(2'h1);
            cur = lvls[i];
            rw(1'b0, `PGAG_OFF_LEVEL_ACT, 16'h0, 1'b0, cur);
            `CHK("read mask", m[11:6], rmask)
            `CHK("write mask", m[5:0], wmask)
            `CHK("level out", cur, lvl)
            for (int g = 0; g < 6; g++) begin
                v = 16'h0a00 + 16'(i * 16 + g);
                rw(1'b1, pa(g, 5), v, !m[g], 16'h0);
                if (m[g]) ex[g] = v;
                rw(1'b0, pa(g, 5), 16'h0, !m[6 + g], m[6 + g] ? ex[g] : 16'h0);
            end
            $display("test level %h done", cur);
        end
        rw(1'b0, `PGAG_OFF_STATUS, 16'h0, 1'b0, 16'h0003);
        rw(1'b1, `PGAG_OFF_STATUS, 16'h0003, 1'b0, 16'h0);
        rw(1'b0, `PGAG_OFF_STATUS, 16'h0, 1'b0, 16'h0000);
        rw(1'b1, pa(0, 19), 16'h100d, 1'b0, 16'h0);
        rw(1'b0, `PGAG_OFF_LEVEL_SET, 16'h0, 1'b0, 16'h100d);
        rw(1'b0, `PGAG_OFF_STATUS, 16'h0, 1'b0, 16'h0004);
        $display("test status done");
        close_out;
    end
endmodule // testbench
`default_nettype wire
